// >>> design/ast_top.sv
/*
  Asynchronous serial transceiver with AXI4-Lite register slave, parity,
  break and idle frames, wake-up and a combined interrupt request.
  Assumes one clock, synchronous active-high reset, synchronous serial input.
*/
// Functional notes
// - idle enabled transmitter or receiver holds the output line high.
// - with both disabled the output driver is released.
// - frame is start bit, 8 or 9 data bits LSB first, stop bit.
// - send-break bit loads a break frame of the selected word length.
// - break frames repeat while set; one high bit follows the last.
// - enabling the transmitter sends one idle frame before data.
// - disable then enable mid-frame sends idle after the current word.
// - re-enabling the transmitter discards the holding buffer contents.
// - nine-bit mode stores the top received bit in control one.
// - receiver enable starts the search for a start bit.
// - finished character moves into the receive buffer, full flag set.
// - full flag interrupts when enabled and CPU mask clear.
// - framing, noise and overrun set separate error flags.
// - full flag clears only by status access then data read.
// - full flag still set at next character end gives overrun.
// - received break counts as framing error.
// - idle frame sets its flag and interrupts when enabled.
// - wake bit 0 selects idle-line, 1 address-mark wake-up.
// - parity inserted at top data bit and checked, from next byte.
// - parity select 0 even, 1 odd, from next byte.
// - parity error interrupts when its enable is set.
// - buffer-empty and transmit-done flags interrupt when enabled.
`default_nettype none
module ast_top #(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // serial pins
  input wire logic serial_in_pin_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  // cpu side
  input wire logic cpu_mask_i,
  output logic irq_o
);
  import ast_pkg::*;

  // parity of the low n data bits, optionally inverted for odd parity
  function automatic logic par_fn(input logic [8:0] d, input logic w9, input logic odd);
    par_fn = (w9 ? ^d[7:0] : ^d[6:0]) ^ odd;
  endfunction : par_fn

  logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [6:0] c1_ff;
  logic [7:0] c2_ff;
  logic [15:0] baud_ff;
  logic [15:0] div_ff;
  logic tick;
  logic [8:0] hold_ff, rxbuf_ff;
  logic r9_ff, tx_buffer_empty_flag_ff, tc_ff, rx_full_flag_ff, idle_ff, ovr_ff, nf_ff, fe_ff, pe_ff;
  logic sr_seen_ff, te_q_ff, idle_pend_ff, brk_last_ff, brk_tail_ff;
  logic rx_w9_ff, rx_pce_ff, rx_ps_ff;
  logic wr_fire, rd_fire, rd_sr, rd_dr, wr_dr, seq_clr;
  logic te, re, send_break_bit, w9, mute;
  logic tx_load, tx_busy, tx_done, tx_line, load_data, load_brk, load_tail, tail_due;
  logic [10:0] tx_frame;
  logic [3:0] tx_len;
  logic rx_done, rx_stop, rx_noise, rx_idle, rx_busy, rx_take, par_bad;
  logic [8:0] rx_data;
  logic [7:0] status;

  assign te = c2_ff[AST_C2_TE];
  assign re = c2_ff[AST_C2_RE];
  assign send_break_bit = c2_ff[AST_C2_SBK];
  assign mute = c2_ff[AST_C2_RWU];
  assign w9 = c1_ff[AST_C1_W9];
  assign status = {tx_buffer_empty_flag_ff, tc_ff, rx_full_flag_ff, idle_ff, ovr_ff, nf_ff, fe_ff, pe_ff};

  // bus handshakes: address and data taken in any order, one write at a time
  assign s_axi_awready_o = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready_o = !w_have_ff && !bvalid_ff;
  assign s_axi_arready_o = !rvalid_ff;
  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  assign rd_fire = s_axi_arvalid_i && !rvalid_ff;
  assign rd_sr = rd_fire && s_axi_araddr_i == ADDR_W'(AST_OFS_STATUS);
  assign rd_dr = rd_fire && s_axi_araddr_i == ADDR_W'(AST_OFS_DATA);
  assign wr_dr = wr_fire && awaddr_ff == ADDR_W'(AST_OFS_DATA) && wstrb_ff[0];
  assign seq_clr = sr_seen_ff && rd_dr;

  // write channel capture and response
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bresp_ff <= AST_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (awaddr_ff > ADDR_W'(AST_OFS_BAUD) || awaddr_ff[1:0] != 2'h0)
                    ? AST_RESP_SLVERR : AST_RESP_OKAY;
      end
      else if (s_axi_bready_i)
        bvalid_ff <= 1'b0;
    end
  end

  // read channel; status and data reads have side effects at the handshake
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= AST_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= AST_RESP_OKAY;
      case (s_axi_araddr_i)
        ADDR_W'(AST_OFS_STATUS): rdata_ff <= {24'h000000, status};
        ADDR_W'(AST_OFS_DATA): rdata_ff <= {24'h000000, rxbuf_ff[7:0]};
        ADDR_W'(AST_OFS_CTRL1): rdata_ff <= {24'h000000, r9_ff, c1_ff};
        ADDR_W'(AST_OFS_CTRL2): rdata_ff <= {24'h000000, c2_ff};
        ADDR_W'(AST_OFS_BAUD): rdata_ff <= {16'h0000, baud_ff};
        default:
        begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= AST_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready_i)
      rvalid_ff <= 1'b0;
  end

  // control registers; hardware clears the mute bit on wake-up
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c1_ff <= AST_RST_CTRL[6:0];
      c2_ff <= AST_RST_CTRL;
      baud_ff <= AST_RST_BAUD;
    end
    else
    begin
      if (wr_fire && wstrb_ff[0] && awaddr_ff == ADDR_W'(AST_OFS_CTRL1))
        c1_ff <= wdata_ff[6:0] & AST_C1_WMASK;
      if (wr_fire && wstrb_ff[0] && awaddr_ff == ADDR_W'(AST_OFS_CTRL2))
        c2_ff <= wdata_ff[7:0];
      else if (mute && (c1_ff[AST_C1_WAKE] ? rx_done && rx_data[rx_w9_ff ? 8 : 7] : rx_idle))
        c2_ff[AST_C2_RWU] <= 1'b0;
      if (wr_fire && awaddr_ff == ADDR_W'(AST_OFS_BAUD))
      begin
        if (wstrb_ff[0])
          baud_ff[7:0] <= wdata_ff[7:0];
        if (wstrb_ff[1])
          baud_ff[15:8] <= wdata_ff[15:8];
      end
    end
  end

  // sample tick at sixteen times the bit rate
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      div_ff <= 16'h0000;
    else
      div_ff <= div_ff + 16'h0001;
  end
  assign tick = (div_ff >= baud_ff);

  // transmit scheduling: idle first, then break, break tail, then data
  // a finished break owes its high tail bit before any waiting data frame
  assign tail_due = brk_tail_ff || (brk_last_ff && !send_break_bit);
  assign tx_load = te && !tx_busy && (idle_pend_ff || send_break_bit || tail_due || !tx_buffer_empty_flag_ff);
  assign load_brk = tx_load && !idle_pend_ff && send_break_bit;
  assign load_tail = tx_load && !idle_pend_ff && !send_break_bit && tail_due;
  assign load_data = tx_load && !idle_pend_ff && !send_break_bit && !tail_due;
  always_comb
  begin
    tx_len = w9 ? AST_LEN_W9 : AST_LEN_W8;
    tx_frame = 11'h7FF; // idle frame is all ones
    if (load_brk)
      tx_frame = 11'h000;
    else if (load_tail)
      tx_len = 4'h1;
    else if (load_data)
    begin
      tx_frame = {1'b1, w9 ? hold_ff[8] : 1'b1, hold_ff[7:0], 1'b0};
      if (c1_ff[AST_C1_PCE])
      begin
        if (w9)
          tx_frame[9] = par_fn(hold_ff, 1'b1, c1_ff[AST_C1_PS]);
        else
          tx_frame[8] = par_fn(hold_ff, 1'b0, c1_ff[AST_C1_PS]);
      end
    end
  end

  // transmit bookkeeping around enable toggles and break
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      te_q_ff <= 1'b0;
      idle_pend_ff <= 1'b0;
      brk_last_ff <= 1'b0;
      brk_tail_ff <= 1'b0;
    end
    else
    begin
      te_q_ff <= te;
      if (te && !te_q_ff)
        idle_pend_ff <= 1'b1;
      else if (tx_load)
        idle_pend_ff <= 1'b0;
      if (tx_load)
        brk_last_ff <= load_brk;
      if (brk_last_ff && !send_break_bit && !brk_tail_ff && !tx_busy && !tx_load)
        brk_tail_ff <= 1'b1;
      else if (load_tail || load_brk)
        brk_tail_ff <= 1'b0;
    end
  end

  // holding buffer and its flags; set wins over software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_ff <= 9'h000;
      tx_buffer_empty_flag_ff <= 1'b1;
      tc_ff <= 1'b1;
      sr_seen_ff <= 1'b0;
    end
    else
    begin
      if (wr_dr)
        hold_ff <= {c1_ff[AST_C1_T9], wdata_ff[7:0]};
      if ((te && !te_q_ff) || load_data)
        tx_buffer_empty_flag_ff <= 1'b1;
      else if (wr_dr)
        tx_buffer_empty_flag_ff <= 1'b0;
      if (tx_done && tx_buffer_empty_flag_ff && !idle_pend_ff && !send_break_bit && !tail_due)
        tc_ff <= 1'b1;
      else if (sr_seen_ff && wr_dr)
        tc_ff <= 1'b0;
      if (rd_sr)
        sr_seen_ff <= 1'b1;
      else if (rd_dr || wr_dr)
        sr_seen_ff <= 1'b0;
    end
  end

  ast_tx_shift u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .load_i(tx_load),
    .frame_i(tx_frame),
    .len_i(tx_len),
    .line_o(tx_line),
    .busy_o(tx_busy),
    .done_o(tx_done)
  );

  // line stays high while idle; driver released when both directions are off
  assign serial_out_o = tx_line;
  assign serial_out_oe_n_o = !(te || re);

  ast_rx_shift u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(re),
    .tick_i(tick),
    .word9_i(rx_w9_ff),
    .rxd_i(serial_in_pin_i),
    .done_o(rx_done),
    .data_o(rx_data),
    .stop_o(rx_stop),
    .noise_o(rx_noise),
    .idle_o(rx_idle),
    .busy_o(rx_busy)
  );

  // receive format latched between frames so changes apply from the next byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_w9_ff <= 1'b0;
      rx_pce_ff <= 1'b0;
      rx_ps_ff <= 1'b0;
    end
    else if (!rx_busy)
    begin
      rx_w9_ff <= w9;
      rx_pce_ff <= c1_ff[AST_C1_PCE];
      rx_ps_ff <= c1_ff[AST_C1_PS];
    end
  end

  // a muted receiver ignores characters except the address mark that wakes it
  assign rx_take = rx_done && re && (!mute || c1_ff[AST_C1_WAKE] && rx_data[rx_w9_ff ? 8 : 7]);
  assign par_bad = rx_pce_ff && (rx_data[rx_w9_ff ? 8 : 7] != par_fn(rx_data, rx_w9_ff, rx_ps_ff));

  // receive buffer and error flags; an overrun keeps the older character
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rxbuf_ff <= 9'h000;
      r9_ff <= 1'b0;
      {rx_full_flag_ff, idle_ff, ovr_ff, nf_ff, fe_ff, pe_ff} <= 6'h00;
    end
    else
    begin
      if (seq_clr)
        {rx_full_flag_ff, idle_ff, ovr_ff, nf_ff, fe_ff, pe_ff} <= 6'h00;
      if (rx_idle && re && !mute)
        idle_ff <= 1'b1;
      if (rx_take && rx_full_flag_ff && !seq_clr)
        ovr_ff <= 1'b1;
      else if (rx_take)
      begin
        rxbuf_ff <= rx_data;
        rx_full_flag_ff <= 1'b1;
        if (rx_w9_ff)
          r9_ff <= rx_data[8];
        fe_ff <= !rx_stop;
        nf_ff <= rx_noise;
        pe_ff <= par_bad;
      end
    end
  end

  // one request line gated by the cpu mask
  assign irq_o = !cpu_mask_i && ((c2_ff[AST_C2_TIE] && tx_buffer_empty_flag_ff)
    || (c2_ff[AST_C2_TX_DONE_IRQ_ON] && tc_ff)
    || (c2_ff[AST_C2_RIE] && (rx_full_flag_ff || ovr_ff))
    || (c2_ff[AST_C2_IDLE_IRQ_ON] && idle_ff)
    || (c1_ff[AST_C1_PIE] && pe_ff));

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_IDLE_HIGH: assert property ((te || re) && !tx_busy |-> serial_out_o)
    else $error("line not high while idle");
  AST_RELEASE: assert property (!te && !re |-> serial_out_oe_n_o)
    else $error("driver not released");
  AST_START_LOW: assert property (load_data |=> !serial_out_o && tx_busy)
    else $error("data frame missing start bit");
  AST_IDLE_FIRST: assert property (te && !te_q_ff |=> idle_pend_ff && tx_buffer_empty_flag_ff)
    else $error("enable did not queue idle frame");
  AST_FULL_SET: assert property (rx_take && !rx_full_flag_ff |=> rx_full_flag_ff && rxbuf_ff == $past(rx_data))
    else $error("received character not buffered");
  AST_OVERRUN: assert property (rx_take && rx_full_flag_ff && !seq_clr |=> ovr_ff && $stable(rxbuf_ff))
    else $error("overrun not flagged");
  AST_FRAMING: assert property (rx_take && !rx_full_flag_ff && !rx_stop |=> fe_ff)
    else $error("break or bad stop not framing error");
  AST_FULL_HOLD: assert property (rx_full_flag_ff && !seq_clr |=> rx_full_flag_ff)
    else $error("full flag cleared without sequence");
  AST_MASKED: assert property (cpu_mask_i |-> !irq_o)
    else $error("request while cpu masked");
  AST_PAR_IRQ: assert property (c1_ff[AST_C1_PIE] && pe_ff && !cpu_mask_i |-> irq_o)
    else $error("parity error not requested");

  COV_DATA_TX: cover property (load_data ##[1:1000] tx_done);
  COV_RX_CHAR: cover property (rx_take && !rx_full_flag_ff);
  COV_OVERRUN: cover property (rx_take && rx_full_flag_ff);
  COV_BREAK_TAIL: cover property (load_tail);
endmodule : ast_top
`default_nettype wire

// >>> design/ast_pkg.sv
/*
  Shared constants of the asynchronous serial transceiver: register byte
  offsets, field positions, reset values and bit timing.
  Assumes a 32-bit AXI4-Lite register bus with one word per register.
*/
`default_nettype none
package ast_pkg;
  // register byte offsets
  localparam logic [7:0] AST_OFS_STATUS = 8'h00;
  localparam logic [7:0] AST_OFS_DATA = 8'h04;
  localparam logic [7:0] AST_OFS_CTRL1 = 8'h08;
  localparam logic [7:0] AST_OFS_CTRL2 = 8'h0C;
  localparam logic [7:0] AST_OFS_BAUD = 8'h10;
  // status field positions
  localparam int AST_SR_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int AST_SR_TC = 6;
  localparam int AST_SR_RX_FULL_FLAG = 5;
  localparam int AST_SR_IDLE = 4;
  localparam int AST_SR_OVR = 3;
  localparam int AST_SR_NF = 2;
  localparam int AST_SR_FE = 1;
  localparam int AST_SR_PE = 0;
  // control one field positions
  localparam int AST_C1_R9 = 7;
  localparam int AST_C1_T9 = 6;
  localparam int AST_C1_W9 = 4;
  localparam int AST_C1_WAKE = 3;
  localparam int AST_C1_PCE = 2;
  localparam int AST_C1_PS = 1;
  localparam int AST_C1_PIE = 0;
  // control two field positions
  localparam int AST_C2_TIE = 7;
  localparam int AST_C2_TX_DONE_IRQ_ON = 6;
  localparam int AST_C2_RIE = 5;
  localparam int AST_C2_IDLE_IRQ_ON = 4;
  localparam int AST_C2_TE = 3;
  localparam int AST_C2_RE = 2;
  localparam int AST_C2_RWU = 1;
  localparam int AST_C2_SBK = 0;
  // reset values
  localparam logic [7:0] AST_RST_CTRL = 8'h00;
  localparam logic [15:0] AST_RST_BAUD = 16'h0043;
  localparam logic [6:0] AST_C1_WMASK = 7'h5F;
  // timing: samples per bit and frame lengths in bits
  localparam logic [3:0] AST_OVS_LAST = 4'hF;
  localparam logic [3:0] AST_LEN_W8 = 4'hA;
  localparam logic [3:0] AST_LEN_W9 = 4'hB;
  localparam logic [1:0] AST_RESP_OKAY = 2'h0;
  localparam logic [1:0] AST_RESP_SLVERR = 2'h2;
endpackage : ast_pkg
`default_nettype wire

// >>> design/ast_tx_shift.sv
/*
  Transmit shifter: sends a prebuilt frame of up to 11 bits, LSB first,
  one bit per 16 sample ticks.
  Assumes the caller loads only while busy_o is low.
*/
`default_nettype none
module ast_tx_shift
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // timing and frame
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [10:0] frame_i,
  input wire logic [3:0] len_i,
  // line and status
  output logic line_o,
  output logic busy_o,
  output logic done_o
);
  import ast_pkg::*;

  logic [10:0] sh_ff;
  logic [3:0] left_ff;
  logic [3:0] sub_ff;
  logic busy_ff;
  logic done_ff;

  // shift a bit out after each full bit time; idle line is high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh_ff <= 11'h7FF;
      left_ff <= 4'h0;
      sub_ff <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (load_i)
      begin
        sh_ff <= frame_i;
        left_ff <= len_i;
        sub_ff <= 4'h0;
        busy_ff <= 1'b1;
      end
      else if (busy_ff && tick_i)
      begin
        sub_ff <= sub_ff + 4'h1;
        if (sub_ff == AST_OVS_LAST)
        begin
          sh_ff <= {1'b1, sh_ff[10:1]};
          left_ff <= left_ff - 4'h1;
          if (left_ff == 4'h1)
          begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
          end
        end
      end
    end
  end

  assign line_o = busy_ff ? sh_ff[0] : 1'b1;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
endmodule : ast_tx_shift
`default_nettype wire

// >>> design/ast_rx_shift.sv
/*
  Receive shifter: 16x oversampled start search, majority vote on samples
  7, 8 and 9 of each bit, idle frame detection.
  Assumes the serial input is already synchronous to clk_i.
*/
`default_nettype none
module ast_rx_shift
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic word9_i,
  input wire logic rxd_i,
  // results
  output logic done_o,
  output logic [8:0] data_o,
  output logic stop_o,
  output logic noise_o,
  output logic idle_o,
  output logic busy_o
);
  import ast_pkg::*;

  typedef enum logic [1:0] {AST_RX_IDLE, AST_RX_START, AST_RX_BITS, AST_RX_STOP} ast_rx_t;
  ast_rx_t st_ff;
  logic [3:0] sub_ff;
  logic [3:0] idx_ff;
  logic [1:0] smp_ff;
  logic vote;
  logic [8:0] data_ff;
  logic noise_ff;
  logic stop_ff;
  logic done_ff;
  logic [7:0] hi_ff;
  logic armed_ff;
  logic idle_ff;

  assign vote = (smp_ff[0] & smp_ff[1]) | (rxd_i & (smp_ff[0] | smp_ff[1]));

  // frame sampler; a start bit that fails its vote is a false start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= AST_RX_IDLE;
      sub_ff <= 4'h0;
      idx_ff <= 4'h0;
      smp_ff <= 2'h3;
      data_ff <= 9'h000;
      noise_ff <= 1'b0;
      stop_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (!en_i)
        st_ff <= AST_RX_IDLE;
      else if (tick_i)
      begin
        sub_ff <= sub_ff + 4'h1;
        if (sub_ff == 4'h7)
          smp_ff[0] <= rxd_i;
        if (sub_ff == 4'h8)
          smp_ff[1] <= rxd_i;
        if (sub_ff == 4'h9 && st_ff != AST_RX_IDLE)
        begin
          if (smp_ff[0] != rxd_i || smp_ff[1] != rxd_i)
            noise_ff <= 1'b1;
          case (st_ff)
            AST_RX_START: if (vote) st_ff <= AST_RX_IDLE;
            AST_RX_BITS: data_ff[idx_ff] <= vote;
            AST_RX_STOP:
            begin
              stop_ff <= vote;
              done_ff <= 1'b1;
              st_ff <= AST_RX_IDLE;
            end
            default: st_ff <= AST_RX_IDLE;
          endcase
        end
        if (sub_ff == AST_OVS_LAST && st_ff == AST_RX_START)
        begin
          st_ff <= AST_RX_BITS;
          idx_ff <= 4'h0;
        end
        if (sub_ff == AST_OVS_LAST && st_ff == AST_RX_BITS)
        begin
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == (word9_i ? 4'h8 : 4'h7))
            st_ff <= AST_RX_STOP;
        end
        if (st_ff == AST_RX_IDLE && !rxd_i)
        begin
          st_ff <= AST_RX_START;
          sub_ff <= 4'h1;
          noise_ff <= 1'b0;
          data_ff <= 9'h000;
        end
      end
    end
  end

  // idle frame: line high for one whole frame after reset or after a reception
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_ff <= 8'h00;
      armed_ff <= 1'b1;
      idle_ff <= 1'b0;
    end
    else
    begin
      idle_ff <= 1'b0;
      if (!en_i || !rxd_i || st_ff != AST_RX_IDLE)
      begin
        hi_ff <= 8'h00;
        if (st_ff != AST_RX_IDLE)
          armed_ff <= 1'b1;
      end
      else if (tick_i && armed_ff)
      begin
        hi_ff <= hi_ff + 8'h01;
        if (hi_ff[7:4] == (word9_i ? AST_LEN_W9 : AST_LEN_W8) - 4'h1 && hi_ff[3:0] == AST_OVS_LAST)
        begin
          idle_ff <= 1'b1;
          armed_ff <= 1'b0;
        end
      end
    end
  end

  assign done_o = done_ff;
  assign data_o = data_ff;
  assign stop_o = stop_ff;
  assign noise_o = noise_ff;
  assign idle_o = idle_ff;
  assign busy_o = (st_ff != AST_RX_IDLE);
endmodule : ast_rx_shift
`default_nettype wire

// >>> sim/ast_peer.sv
/*
  Far-side serial device: sends and takes 8-bit frames on the line.
  Assumes a baud divider of 1, so one bit lasts 32 clocks.
*/
`default_nettype none
module ast_peer
(
  // clock
  input wire logic clk_i,
  // line
  input wire logic rx_i,
  output logic tx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 32;
  logic [7:0] got_ff;
  time t_ff;
  // the line idles high between frames
  initial tx_o = 1'h1;
  // start, lsb first, stop; a low stop forms a broken frame
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      tx_o <= f[i];
      repeat (BT) @(posedge clk_i);
    end
    tx_o <= 1'h1;
  endtask : send
  // mid-bit sampling, well away from the edges
  task automatic recv();
    @(negedge rx_i);
    t_ff = $time;
    repeat (BT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BT) @(posedge clk_i);
      got_ff[i] = rx_i;
    end
  endtask : recv
endmodule : ast_peer
`default_nettype wire

// >>> sim/async_serial_transceiver_tb_top.sv
/*
  Bench of the serial transceiver: AXI4-Lite register tasks and a peer.
  Assumes a baud divider of 1, so one bit lasts 32 clocks.
*/
`default_nettype none
module async_serial_transceiver_tb_top;
  import ast_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i;
  logic rst_i = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'h0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'h0;
  logic wready;
  logic bvalid;
  logic [1:0] bresp;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'h0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic mask = 1'h1;
  logic sin;
  logic sout;
  logic oe_n;
  logic irq;
  int err_total = 0;
  int samples_checked = 0;
  ast_top u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'h1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'h1), .serial_in_pin_i(sin),
    .serial_out_o(sout), .serial_out_oe_n_o(oe_n), .cpu_mask_i(mask), .irq_o(irq));
  ast_peer u_peer (.clk_i(clk_i), .rx_i(sout), .tx_o(sin));
  // 125 MHz clock
  initial
  begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // ready is looked at mid-cycle, so the edge that takes it is known
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    logic b;
    logic [1:0] q;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do
    begin
      @(negedge clk_i);
      ta = awvalid & awready;
      tw = wvalid & wready;
      b = (bvalid === 1'h1);
      q = bresp;
      @(posedge clk_i);
      if (ta)
        awvalid <= 1'h0;
      if (tw)
        wvalid <= 1'h0;
    end while (!b);
    chk({30'h0, q}, {30'h0, (a > 8'h10) ? AST_RESP_SLVERR : AST_RESP_OKAY});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] q;
    logic t;
    logic b;
    araddr <= a;
    arvalid <= 1'h1;
    do
    begin
      @(negedge clk_i);
      t = arvalid & arready;
      b = (rvalid === 1'h1);
      d = rdata;
      q = rresp;
      @(posedge clk_i);
      if (t)
        arvalid <= 1'h0;
    end while (!b);
    chk(d & m, e);
    chk({30'h0, q}, {30'h0, (a > 8'h10) ? AST_RESP_SLVERR : AST_RESP_OKAY});
  endtask : rdc
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // main sequence
  initial
  begin
    time t0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    rdc(AST_OFS_STATUS, 32'hFF, 32'hC0);
    rdc(8'h14, 32'hFFFFFFFF, 32'h0);
    wr(8'h14, 32'h0);
    chk(oe_n, 32'h1);
    wr(AST_OFS_BAUD, 32'h1);
    t0 = $time;
    wr(AST_OFS_CTRL2, 32'h0C);
    chk({oe_n, sout}, 32'h1);
    wr(AST_OFS_DATA, 32'hA5);
    u_peer.recv();
    chk(u_peer.got_ff, 32'hA5);
    chk(u_peer.t_ff - t0 >= 2560, 32'h1);
    repeat (64) @(posedge clk_i);
    rdc(AST_OFS_STATUS, 32'hF0, 32'hD0);
    u_peer.send(8'h3C, 1'h1);
    repeat (32) @(posedge clk_i);
    rdc(AST_OFS_STATUS, 32'h20, 32'h20);
    rdc(AST_OFS_DATA, 32'hFF, 32'h3C);
    rdc(AST_OFS_STATUS, 32'h20, 32'h0);
    mask <= 1'h0;
    wr(AST_OFS_CTRL2, 32'h2C);
    u_peer.send(8'h11, 1'h1);
    repeat (32) @(posedge clk_i);
    chk(irq, 32'h1);
    mask <= 1'h1;
    @(posedge clk_i);
    chk(irq, 32'h0);
    u_peer.send(8'h22, 1'h1);
    repeat (32) @(posedge clk_i);
    rdc(AST_OFS_STATUS, 32'h28, 32'h28);
    rdc(AST_OFS_DATA, 32'hFF, 32'h11);
    u_peer.send(8'h00, 1'h0);
    repeat (32) @(posedge clk_i);
    rdc(AST_OFS_STATUS, 32'h02, 32'h02);
    rdc(AST_OFS_DATA, 32'hFF, 32'h00);
    // even parity, parity interrupt on, receive interrupt off
    wr(AST_OFS_CTRL1, 32'h05);
    wr(AST_OFS_CTRL2, 32'h0C);
    u_peer.send(8'h01, 1'h1);
    repeat (32) @(posedge clk_i);
    mask <= 1'h0;
    rdc(AST_OFS_STATUS, 32'h01, 32'h01);
    chk(irq, 32'h1);
    rdc(AST_OFS_DATA, 32'hFF, 32'h01);
    chk(irq, 32'h0);
    wr(AST_OFS_CTRL2, 32'h8C);
    chk(irq, 32'h1);
    // send break: the peer sees a frame of all zeros
    wr(AST_OFS_CTRL2, 32'h0D);
    u_peer.recv();
    chk(u_peer.got_ff, 32'h0);
    close_out();
  end
  // watchdog: the sequence needs about 3000 clocks
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    close_out();
  end
endmodule : async_serial_transceiver_tb_top
`default_nettype wire
